// ==== pst_pkg.sv ====
// Shared constants and carrier types for the status and telemetry bank
package pst_pkg;
  // ==========================================================
  // Command codes
  localparam logic [7:0] CMD_SUM_BYTE  = 8'h78;
  localparam logic [7:0] CMD_SUM_WORD  = 8'h79;
  localparam logic [7:0] CMD_VOUT_FLG  = 8'h7a;
  localparam logic [7:0] CMD_IOUT_FLG  = 8'h7b;
  localparam logic [7:0] CMD_IN_FLG    = 8'h7c;
  localparam logic [7:0] CMD_TEMP_FLG  = 8'h7d;
  localparam logic [7:0] CMD_CML_FLG   = 8'h7e;
  localparam logic [7:0] CMD_MFR_FLG   = 8'h80;
  localparam logic [7:0] CMD_VIN       = 8'h88;
  localparam logic [7:0] CMD_IIN       = 8'h89;
  localparam logic [7:0] CMD_VOUT      = 8'h8b;
  localparam logic [7:0] CMD_IOUT      = 8'h8c;
  localparam logic [7:0] CMD_TEMP      = 8'h8d;
  localparam logic [7:0] CMD_POUT      = 8'h96;
  localparam logic [7:0] CMD_PIN       = 8'h97;
  localparam logic [7:0] CMD_PROTO_REV = 8'h98;
  localparam logic [7:0] CMD_TAG_MAKER = 8'h99;
  localparam logic [7:0] CMD_TAG_MODEL = 8'h9a;
  localparam logic [7:0] CMD_TAG_REV   = 8'h9b;
  localparam logic [7:0] CMD_TAG_DATE  = 8'h9d;
  localparam logic [7:0] CMD_PART_ID   = 8'had;
  localparam logic [7:0] CMD_SI_REV    = 8'hae;
  // ==========================================================
  // Fixed values and supported-bit masks
  localparam logic [7:0]  PROTO_REV_VAL = 8'h33;
  localparam logic [47:0] PART_ID_VAL   = 48'h0000_1234_5678; // Arbitrary value
  localparam logic [15:0] SI_REV_VAL    = 16'h0001;           // Arbitrary value
  localparam logic [23:0] TAG_RST       = 24'h00_0000;
  localparam logic [7:0]  PHASE_ALL     = 8'hff;
  localparam logic [7:0]  VOUT_MASK     = 8'hbc;
  localparam logic [7:0]  IOUT_MASK     = 8'hb8;
  localparam logic [7:0]  IN_MASK       = 8'hdf;
  localparam logic [7:0]  TEMP_MASK     = 8'hc0;
  localparam logic [7:0]  CML_MASK      = 8'hf3;
  localparam logic [7:0]  MFR_MASK      = 8'hf8;
  localparam logic [7:0]  FLG_RST       = 8'h00;
  // ==========================================================
  // Flag bit positions
  localparam int VOUT_OVF_B = 7;
  localparam int IOUT_OCF_B = 7;
  localparam int IN_UVF_B   = 4;
  localparam int CML_IVC_B  = 7;
  localparam int CML_IVD_B  = 6;
  // Current path: quarter-amp mantissa, exponent -2, gain 128 = unity
  localparam logic [4:0]  IOUT_EXP  = 5'h1e;
  localparam int          GAIN_SH   = 7;
  localparam logic [15:0] MANT_MAX  = 16'h03ff;
  localparam logic [15:0] MANT_MIN  = 16'hfc00;
  // ==========================================================
  // Carriers
  typedef struct packed {
    logic        wr;
    logic [7:0]  code;
    logic [7:0]  page;
    logic [7:0]  phase;
    logic [47:0] wdata;
  } pst_req_t;
  typedef struct packed {
    logic [47:0] data;
    logic [2:0]  len;
    logic        err;
  } pst_rsp_t;
endpackage : pst_pkg

// ==== pst_bank.sv ====
// Status flag, telemetry and tracking register bank behind the command port
// What this block does
// R1 - Per-page summary byte: busy, off, vout OV, iout OC, vin UV, temp, cml, other
// R2 - Per-page summary word: byte plus vout, iout, input, maker, power-good groups
// R3 - Per-page vout flags: OV fault, UV warn, UV fault, limit reached, startup timeout
// R4 - Per-page iout flags: OC fault, OC warn, UC fault, sharing fault
// R5 - One unpaged input flag byte: OV, UV, too low, OC, overpower flags
// R6 - Per-page temperature flags: over-temperature fault and warning
// R7 - One unpaged comms flag byte: command, data, PEC, memory, comms, logic
// R8 - Per-page maker flags: reset, external, settling, phase error, stage fault
// R9 - Input voltage word read returns linear11 sensed value
// R10 - Input current word read returns linear11 sensed amperes
// R11 - Output voltage word read returns per-page unsigned linear16 value
// R12 - Output current read by page and phase: FFh total, else ordered phase
// R13 - Output current corrected by per-phase calibration gain and offset
// R14 - Temperature word read returns per-page linear11 degrees
// R15 - Output power read returns per-page linear11 watts
// R16 - Input power read returns linear11 watts
// R17 - Protocol revision byte read always returns fixed 33h
// R18 - Four three-byte tracking blocks, freely writable and readable
// R19 - Part identity block read returns fixed six bytes, not alterable
// R20 - Silicon revision two-byte read is fixed; writes refused as bad data
// R21 - Writing one clears a flag; a still-present condition keeps it set
`timescale 1ns/10ps
module pst_bank #(
  parameter int NUM_PAGES  = 2,
  parameter int NUM_PHASES = 7,
  parameter int PAGE_W     = 1
) (
  input  wire logic                                 clk,
  input  wire logic                                 rst_b,
  input  wire logic                                 req_valid,
  input  wire pst_pkg::pst_req_t                    req,
  output      logic                                 rsp_valid,
  output      pst_pkg::pst_rsp_t                    rsp,
  input  wire logic [NUM_PAGES-1:0]                 busy,
  input  wire logic [NUM_PAGES-1:0]                 output_off,
  input  wire logic [NUM_PAGES-1:0]                 power_good,
  input  wire logic [NUM_PAGES-1:0][7:0]            vout_cond,
  input  wire logic [NUM_PAGES-1:0][7:0]            iout_cond,
  input  wire logic [NUM_PAGES-1:0][7:0]            temp_cond,
  input  wire logic [NUM_PAGES-1:0][7:0]            mfr_cond,
  input  wire logic [7:0]                           input_cond,
  input  wire logic [7:0]                           cml_cond,
  input  wire logic [15:0]                          vin_word,
  input  wire logic [15:0]                          iin_word,
  input  wire logic [15:0]                          pin_word,
  input  wire logic [NUM_PAGES-1:0][15:0]           vout_word,
  input  wire logic [NUM_PAGES-1:0][15:0]           temp_word,
  input  wire logic [NUM_PAGES-1:0][15:0]           pout_word,
  input  wire logic [NUM_PHASES-1:0][11:0]          phase_raw,
  input  wire logic [NUM_PHASES-1:0][7:0]           phase_gain,
  input  wire logic [NUM_PHASES-1:0][11:0]          phase_offset,
  input  wire logic [NUM_PHASES-1:0][PAGE_W-1:0]    phase_page
);

  // ==========================================================
  // Flag and tracking-block storage
  logic [NUM_PAGES-1:0][7:0] vout_flags;
  logic [NUM_PAGES-1:0][7:0] iout_flags;
  logic [NUM_PAGES-1:0][7:0] temp_flags;
  logic [NUM_PAGES-1:0][7:0] mfr_flags;
  logic [7:0]                input_flags;
  logic [7:0]                cml_flags;
  logic [3:0][23:0]          tags;

  // Request decode shared by all processes
  logic       do_wr;
  logic       page_ok;
  logic [PAGE_W-1:0] pg;
  logic       paged;
  logic       known;
  logic       writable;
  logic [7:0] wb;
  logic [7:0] wh;
  assign do_wr   = req_valid && req.wr;
  assign pg      = req.page[PAGE_W-1:0];
  assign page_ok = int'(req.page) < NUM_PAGES;
  assign wb      = req.wdata[7:0];
  assign wh      = req.wdata[15:8];

  // Classify the command code
  always_comb begin
    known    = 1'b1;
    writable = 1'b0;
    paged    = 1'b0;
    unique case (req.code)
      pst_pkg::CMD_SUM_BYTE, pst_pkg::CMD_SUM_WORD, pst_pkg::CMD_VOUT_FLG,
      pst_pkg::CMD_IOUT_FLG, pst_pkg::CMD_TEMP_FLG, pst_pkg::CMD_MFR_FLG: begin
        writable = 1'b1;
        paged    = 1'b1;
      end
      pst_pkg::CMD_IN_FLG, pst_pkg::CMD_CML_FLG, pst_pkg::CMD_TAG_MAKER,
      pst_pkg::CMD_TAG_MODEL, pst_pkg::CMD_TAG_REV, pst_pkg::CMD_TAG_DATE: begin
        writable = 1'b1;
      end
      pst_pkg::CMD_VOUT, pst_pkg::CMD_IOUT, pst_pkg::CMD_TEMP, pst_pkg::CMD_POUT: begin
        paged = 1'b1;
      end
      pst_pkg::CMD_VIN, pst_pkg::CMD_IIN, pst_pkg::CMD_PIN, pst_pkg::CMD_PROTO_REV,
      pst_pkg::CMD_PART_ID, pst_pkg::CMD_SI_REV: begin
        paged = 1'b0;
      end
      default: known = 1'b0;
    endcase
  end

  // Bad data: write to a fixed register, or a page that does not exist
  logic bad_data;
  logic good;
  assign bad_data = known && ((req.wr && !writable) || (paged && !page_ok));
  assign good     = req_valid && known && !bad_data;

  // ==========================================================
  // Clear masks from host writes, one per page for paged flags, a single one each for input and comms
  logic [NUM_PAGES-1:0][7:0] clr_vout;
  logic [NUM_PAGES-1:0][7:0] clr_iout;
  logic [NUM_PAGES-1:0][7:0] clr_temp;
  logic [NUM_PAGES-1:0][7:0] clr_mfr;
  logic [7:0]                clr_in;
  logic [7:0]                clr_cml;
  always_comb begin
    clr_in  = '0;
    clr_cml = '0;
    for (int p = 0; p < NUM_PAGES; p++) begin
      clr_vout[p] = '0;
      clr_iout[p] = '0;
      clr_temp[p] = '0;
      clr_mfr[p]  = '0;
    end
    if (good && req.wr) begin
      unique case (req.code)
        pst_pkg::CMD_VOUT_FLG: clr_vout[pg] = wb; // R21
        pst_pkg::CMD_IOUT_FLG: clr_iout[pg] = wb; // R21
        pst_pkg::CMD_TEMP_FLG: clr_temp[pg] = wb; // R21
        pst_pkg::CMD_MFR_FLG:  clr_mfr[pg]  = wb; // R21
        pst_pkg::CMD_IN_FLG:   clr_in       = wb; // R21
        pst_pkg::CMD_CML_FLG:  clr_cml      = wb; // R21
        // Summary writes clear a whole group per bit written as one: byte bits 2, 1 (temp, cml), word high bits 7-4 (vout, iout, input, maker)
        pst_pkg::CMD_SUM_BYTE, pst_pkg::CMD_SUM_WORD: begin
          clr_temp[pg] = {8{wb[2]}};
          clr_cml      = {8{wb[1]}};
          if (req.code == pst_pkg::CMD_SUM_WORD) begin
            clr_vout[pg] = {8{wh[7]}};
            clr_iout[pg] = {8{wh[6]}};
            clr_in       = {8{wh[5]}};
            clr_mfr[pg]  = {8{wh[4]}};
          end
        end
        default: clr_in = '0;
      endcase
    end
  end

  // ==========================================================
  // Sticky paged flags; a set in the clearing cycle wins
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      for (int p = 0; p < NUM_PAGES; p++) begin
        vout_flags[p] <= pst_pkg::FLG_RST;
        iout_flags[p] <= pst_pkg::FLG_RST;
        temp_flags[p] <= pst_pkg::FLG_RST;
        mfr_flags[p]  <= pst_pkg::FLG_RST;
      end
    end else begin
      for (int p = 0; p < NUM_PAGES; p++) begin
        vout_flags[p] <= (vout_flags[p] & ~clr_vout[p]) | (vout_cond[p] & pst_pkg::VOUT_MASK); // R3 R21
        iout_flags[p] <= (iout_flags[p] & ~clr_iout[p]) | (iout_cond[p] & pst_pkg::IOUT_MASK); // R4 R21
        temp_flags[p] <= (temp_flags[p] & ~clr_temp[p]) | (temp_cond[p] & pst_pkg::TEMP_MASK); // R6 R21
        mfr_flags[p]  <= (mfr_flags[p] & ~clr_mfr[p]) | (mfr_cond[p] & pst_pkg::MFR_MASK); // R8 R21
      end
    end
  end

  // Unpaged flags; the command path itself raises bad command and bad data
  logic [7:0] cml_evt;
  always_comb begin
    cml_evt = cml_cond & pst_pkg::CML_MASK;
    cml_evt[pst_pkg::CML_IVC_B] = cml_cond[pst_pkg::CML_IVC_B] || (req_valid && !known);
    cml_evt[pst_pkg::CML_IVD_B] = cml_cond[pst_pkg::CML_IVD_B] || (req_valid && bad_data);
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      input_flags <= pst_pkg::FLG_RST;
      cml_flags   <= pst_pkg::FLG_RST;
    end else begin
      input_flags <= (input_flags & ~clr_in) | (input_cond & pst_pkg::IN_MASK); // R5 R21
      cml_flags   <= (cml_flags & ~clr_cml) | cml_evt; // R7 R21
    end
  end

  // ==========================================================
  // Tracking blocks; held in place of the nonvolatile copy
  logic [1:0] tag_sel;
  always_comb begin
    unique case (req.code)
      pst_pkg::CMD_TAG_MODEL: tag_sel = 2'd1;
      pst_pkg::CMD_TAG_REV:   tag_sel = 2'd2;
      pst_pkg::CMD_TAG_DATE:  tag_sel = 2'd3;
      default:                tag_sel = 2'd0;
    endcase
  end

  logic tag_cmd;
  assign tag_cmd = (req.code == pst_pkg::CMD_TAG_MAKER) || (req.code == pst_pkg::CMD_TAG_MODEL) ||
                   (req.code == pst_pkg::CMD_TAG_REV) || (req.code == pst_pkg::CMD_TAG_DATE);

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      for (int t = 0; t < 4; t++) begin
        tags[t] <= pst_pkg::TAG_RST;
      end
    end else if (good && req.wr && tag_cmd) begin
      tags[tag_sel] <= req.wdata[23:0]; // R18
    end
  end

  // ==========================================================
  // Calibrated phase currents and the ordered or total pick
  logic signed [15:0] iout_sum;
  logic signed [15:0] iout_pick;
  logic signed [15:0] ph_cal;
  logic signed [20:0] ph_prod;
  logic [7:0]         order;
  logic               found;
  logic [15:0]        iout_word;
  always_comb begin
    iout_sum  = '0;
    iout_pick = '0;
    order     = '0;
    found     = 1'b0;
    ph_cal    = '0;
    ph_prod   = '0;
    for (int i = 0; i < NUM_PHASES; i++) begin
      ph_prod = $signed(phase_raw[i]) * $signed({1'b0, phase_gain[i]}); // R13
      ph_cal  = 16'(ph_prod >>> pst_pkg::GAIN_SH) + 16'($signed(phase_offset[i])); // R13
      if (phase_page[i] == pg) begin
        iout_sum = iout_sum + ph_cal; // R12
        if (order == req.phase) begin
          iout_pick = ph_cal; // R12
          found     = 1'b1;
        end
        order = order + 8'd1;
      end
    end
    if (req.phase == pst_pkg::PHASE_ALL) begin
      iout_pick = iout_sum; // R12
      found     = 1'b1;
    end
    // Clamp to the 11-bit mantissa rather than let it wrap in sign
    if (iout_pick > $signed(pst_pkg::MANT_MAX)) begin
      iout_pick = $signed(pst_pkg::MANT_MAX);
    end else if (iout_pick < $signed(pst_pkg::MANT_MIN)) begin
      iout_pick = $signed(pst_pkg::MANT_MIN);
    end
    iout_word = {pst_pkg::IOUT_EXP, iout_pick[10:0]};
  end

  // ==========================================================
  // Summary byte and word for the addressed page
  logic [7:0]  sum_byte;
  logic [15:0] sum_word;
  always_comb begin
    sum_byte = {busy[pg], output_off[pg],
                vout_flags[pg][pst_pkg::VOUT_OVF_B],
                iout_flags[pg][pst_pkg::IOUT_OCF_B],
                input_flags[pst_pkg::IN_UVF_B],
                |temp_flags[pg], |cml_flags, |mfr_flags[pg]}; // R1
    sum_word = {|vout_flags[pg], |iout_flags[pg], |input_flags, |mfr_flags[pg],
                ~power_good[pg], 3'b000, sum_byte}; // R2
  end

  // ==========================================================
  // Read data selection
  pst_pkg::pst_rsp_t next_rsp;
  always_comb begin
    next_rsp      = '0;
    next_rsp.err  = !known || bad_data;
    if (!next_rsp.err && !req.wr) begin
      unique case (req.code)
        pst_pkg::CMD_SUM_BYTE: next_rsp.data[7:0]  = sum_byte; // R1
        pst_pkg::CMD_SUM_WORD: next_rsp.data[15:0] = sum_word; // R2
        pst_pkg::CMD_VOUT_FLG: next_rsp.data[7:0]  = vout_flags[pg]; // R3
        pst_pkg::CMD_IOUT_FLG: next_rsp.data[7:0]  = iout_flags[pg]; // R4
        pst_pkg::CMD_IN_FLG:   next_rsp.data[7:0]  = input_flags; // R5
        pst_pkg::CMD_TEMP_FLG: next_rsp.data[7:0]  = temp_flags[pg]; // R6
        pst_pkg::CMD_CML_FLG:  next_rsp.data[7:0]  = cml_flags; // R7
        pst_pkg::CMD_MFR_FLG:  next_rsp.data[7:0]  = mfr_flags[pg]; // R8
        pst_pkg::CMD_VIN:      next_rsp.data[15:0] = vin_word; // R9
        pst_pkg::CMD_IIN:      next_rsp.data[15:0] = iin_word; // R10
        pst_pkg::CMD_VOUT:     next_rsp.data[15:0] = vout_word[pg]; // R11
        pst_pkg::CMD_IOUT:     next_rsp.data[15:0] = found ? iout_word : 16'h0000; // R12
        pst_pkg::CMD_TEMP:     next_rsp.data[15:0] = temp_word[pg]; // R14
        pst_pkg::CMD_POUT:     next_rsp.data[15:0] = pout_word[pg]; // R15
        pst_pkg::CMD_PIN:      next_rsp.data[15:0] = pin_word; // R16
        pst_pkg::CMD_PROTO_REV: next_rsp.data[7:0] = pst_pkg::PROTO_REV_VAL; // R17
        pst_pkg::CMD_PART_ID:  next_rsp.data       = pst_pkg::PART_ID_VAL; // R19
        pst_pkg::CMD_SI_REV:   next_rsp.data[15:0] = pst_pkg::SI_REV_VAL; // R20
        default:               next_rsp.data[23:0] = tags[tag_sel]; // R18
      endcase
      // Phase index past the page's phases answers with an error, without raising the bad data flag
      if (req.code == pst_pkg::CMD_IOUT && !found) begin
        next_rsp.err = 1'b1;
      end
    end
    unique case (req.code)
      pst_pkg::CMD_SUM_BYTE, pst_pkg::CMD_VOUT_FLG, pst_pkg::CMD_IOUT_FLG,
      pst_pkg::CMD_IN_FLG, pst_pkg::CMD_TEMP_FLG, pst_pkg::CMD_CML_FLG,
      pst_pkg::CMD_MFR_FLG, pst_pkg::CMD_PROTO_REV: next_rsp.len = 3'd1;
      pst_pkg::CMD_TAG_MAKER, pst_pkg::CMD_TAG_MODEL, pst_pkg::CMD_TAG_REV,
      pst_pkg::CMD_TAG_DATE: next_rsp.len = 3'd3;
      pst_pkg::CMD_PART_ID:  next_rsp.len = 3'd6;
      default:               next_rsp.len = known ? 3'd2 : 3'd0;
    endcase
  end

  // One response per request, one cycle later
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rsp_valid <= 1'b0;
      rsp       <= '0;
    end else begin
      rsp_valid <= req_valid;
      if (req_valid) begin
        rsp <= next_rsp;
      end
    end
  end

  // ==========================================================
  // Checks
  // Summary must agree with the page 0 overvoltage flag when page 0 is addressed
  logic sum_word_hold;
  assign sum_word_hold = (pg != '0) || sum_byte[5];
  rsp_timing_a: assert property (@(posedge clk) disable iff (!rst_b)
    req_valid |=> rsp_valid ##1 (rsp_valid == $past(req_valid)))
    else $error("response not one cycle after request");
  rev_fixed_a: assert property (@(posedge clk) disable iff (!rst_b) // R17
    (req_valid && !req.wr && req.code == pst_pkg::CMD_PROTO_REV)
    |=> (rsp.data[7:0] == 8'h33) && (rsp.len == 3'd1) && !rsp.err)
    else $error("protocol revision read wrong");
  part_id_a: assert property (@(posedge clk) disable iff (!rst_b) // R19
    (req_valid && !req.wr && req.code == pst_pkg::CMD_PART_ID)
    |=> (rsp.data == pst_pkg::PART_ID_VAL) && (rsp.len == 3'd6))
    else $error("part identity read wrong");
  si_rev_wr_a: assert property (@(posedge clk) disable iff (!rst_b) // R20
    (req_valid && req.wr && req.code == pst_pkg::CMD_SI_REV)
    |=> rsp.err && cml_flags[pst_pkg::CML_IVD_B])
    else $error("silicon revision write not refused");
  vout_sticky_a: assert property (@(posedge clk) disable iff (!rst_b) // R21
    vout_cond[0][pst_pkg::VOUT_OVF_B] |=> vout_flags[0][pst_pkg::VOUT_OVF_B] [*1]
    ##0 sum_word_hold)
    else $error("overvoltage flag lost while condition present");
  input_hold_a: assert property (@(posedge clk) disable iff (!rst_b) // R5
    ($rose(input_flags[0]) && !clr_in[0])
    |=> input_flags[0])
    else $error("input flag dropped without clear");
  bad_cmd_a: assert property (@(posedge clk) disable iff (!rst_b) // R7
    (req_valid && !known) |=> cml_flags[pst_pkg::CML_IVC_B] && rsp.err)
    else $error("unknown command not flagged");
  tag_store_a: assert property (@(posedge clk) disable iff (!rst_b) // R18
    (req_valid && req.wr && req.code == pst_pkg::CMD_TAG_DATE)
    |=> tags[3] == $past(req.wdata[23:0]))
    else $error("date tag not stored");
  clear_a: assert property (@(posedge clk) disable iff (!rst_b) // R21
    (req_valid && req.wr && req.code == pst_pkg::CMD_TEMP_FLG && req.page == 8'h00
     && req.wdata[7] && !temp_cond[0][7]) |=> !temp_flags[0][7])
    else $error("temperature fault flag not cleared");

endmodule : pst_bank

// ==== pst_host.sv ====
// Host-side request driver standing in for the bus controller
`timescale 1ns/10ps
module pst_host (
  input  wire logic              clk,
  input  wire logic              rsp_valid,
  input  wire pst_pkg::pst_rsp_t rsp,
  output      logic              req_valid,
  output      pst_pkg::pst_req_t req
);
  // ==========================================================
  // Idle bus at time zero
  initial begin
    req_valid = 1'b0;
    req       = '0;
  end
  // One request; fields move only after an edge, answer awaited under a bound
  task automatic xfer(input logic wr, input logic [7:0] code, input logic [7:0] page,
                      input logic [7:0] phase, input logic [47:0] wdata,
                      output pst_pkg::pst_rsp_t r, output bit ok);
    ok = 1'b0;
    r  = '0;
    @(posedge clk);
    req_valid <= 1'b1;
    req       <= '{wr: wr, code: code, page: page, phase: phase, wdata: wdata};
    @(posedge clk);
    req_valid <= 1'b0;
    req.wdata <= ~wdata; // Released data must not look valid
    for (int i = 0; i < 4 && !ok; i++) begin
      @(posedge clk);
      if (rsp_valid === 1'b1) begin
        ok = 1'b1;
        r  = rsp;
      end
    end
  endtask : xfer
endmodule : pst_host

// ==== testbench.sv ====
// Self-checking bench for the status and telemetry bank
`timescale 1ns/10ps
module testbench;
  logic                    clk, rst_b, req_valid, rsp_valid;
  pst_pkg::pst_req_t       req;
  pst_pkg::pst_rsp_t       rsp, r;
  logic [1:0]              busy, output_off, power_good;
  logic [1:0][7:0]         vout_cond, iout_cond, temp_cond, mfr_cond;
  logic [7:0]              input_cond, cml_cond;
  logic [15:0]             vin_word, iin_word, pin_word;
  logic [1:0][15:0]        vout_word, temp_word, pout_word;
  logic [6:0][11:0]        phase_raw, phase_offset;
  logic [6:0][7:0]         phase_gain;
  logic [6:0][0:0]         phase_page;
  int                      errors, checks_done;
  bit                      ok;
  localparam logic [51:0]  EM = 52'h0_0000_0000_0001; // Error bit only, lowest in the carrier
  pst_bank dut (.clk, .rst_b, .req_valid, .req, .rsp_valid, .rsp, .busy, .output_off,
    .power_good, .vout_cond, .iout_cond, .temp_cond, .mfr_cond, .input_cond, .cml_cond,
    .vin_word, .iin_word, .pin_word, .vout_word, .temp_word, .pout_word, .phase_raw,
    .phase_gain, .phase_offset, .phase_page);
  pst_host host (.clk, .rsp_valid, .rsp, .req_valid, .req);
  // ==========================================================
  // Clock, 25 ns period
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  task automatic print_verdict();
    $display("errors=%0d checks_done=%0d", errors, checks_done);
    if (errors == 0 && checks_done > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : print_verdict
  // Compare {data, len, err} under a mask; a lost answer ends the run
  task automatic acc(input logic wr, input logic [7:0] code, input logic [7:0] page,
                     input logic [7:0] ph, input logic [47:0] wd, input logic [51:0] exp,
                     input logic [51:0] m);
    host.xfer(wr, code, page, ph, wd, r, ok);
    checks_done++;
    if (!ok) begin
      errors++;
      $display("BAD t=%0t no answer to %h", $time, code);
      print_verdict();
    end else if ((52'(r) & m) !== exp) begin
      errors++;
      $display("BAD t=%0t cmd %h got %h exp %h", $time, code, 52'(r) & m, exp);
    end
  endtask : acc
  task automatic rd(input logic [7:0] c, input logic [7:0] pg, input logic [7:0] ph,
                    input logic [47:0] d, input logic [2:0] len);
    acc(1'b0, c, pg, ph, 48'h0, {d, len, 1'b0}, '1);
  endtask : rd
  task automatic wr(input logic [7:0] c, input logic [7:0] pg, input logic [47:0] d,
                    input logic e);
    acc(1'b1, c, pg, 8'h0, d, {51'h0, e}, 52'h1);
  endtask : wr
  // ==========================================================
  // Main sequence
  initial begin
    logic [7:0] tags [4];
    tags = '{pst_pkg::CMD_TAG_MAKER, pst_pkg::CMD_TAG_MODEL, pst_pkg::CMD_TAG_REV,
             pst_pkg::CMD_TAG_DATE};
    errors = 0;
    checks_done = 0;
    rst_b = 1'b0;
    {busy, output_off, vout_cond, iout_cond, temp_cond, mfr_cond, input_cond} = '0;
    cml_cond = 8'h00;
    power_good = 2'b11;
    {vin_word, iin_word, pin_word} = {16'h1234, 16'h2345, 16'h3456};
    vout_word = {16'h4567, 16'h5678};
    temp_word = {16'h6789, 16'h789a};
    pout_word = {16'h89ab, 16'h9abc};
    phase_raw = '0;
    phase_offset = '0;
    phase_gain = {7{8'h80}};
    phase_page = 7'b111_1100; // Phases 0 and 1 belong to page 0
    phase_raw[0] = 12'h010;
    phase_raw[1] = 12'h008;
    phase_gain[1] = 8'h40; // Half gain: 8 quarter amps become 4
    phase_offset[1] = 12'h004;
    repeat (8) @(posedge clk);
    rst_b <= 1'b1;
    rd(pst_pkg::CMD_PROTO_REV, 0, 0, 48'h33, 1);
    rd(pst_pkg::CMD_PART_ID, 0, 0, pst_pkg::PART_ID_VAL, 6);
    wr(pst_pkg::CMD_PART_ID, 0, 48'hffff_ffff_ffff, 1);
    rd(pst_pkg::CMD_PART_ID, 0, 0, pst_pkg::PART_ID_VAL, 6);
    wr(pst_pkg::CMD_SI_REV, 0, 48'hffff, 1);
    rd(pst_pkg::CMD_SI_REV, 0, 0, pst_pkg::SI_REV_VAL, 2);
    // Tags start cleared, then take any value independently
    foreach (tags[i]) rd(tags[i], 0, 0, 48'h0, 3);
    foreach (tags[i]) wr(tags[i], 0, 48'hff_ab_cd00 | 48'(i), 0);
    foreach (tags[i]) rd(tags[i], 0, 0, 48'hab_cd00 | 48'(i), 3);
    // Paged vout and temperature words read from page 1, output power from page 0, so page selection matters
    rd(pst_pkg::CMD_VIN, 1, 0, 48'h1234, 2);
    rd(pst_pkg::CMD_IIN, 1, 0, 48'h2345, 2);
    rd(pst_pkg::CMD_PIN, 0, 0, 48'h3456, 2);
    rd(pst_pkg::CMD_VOUT, 1, 0, 48'h4567, 2);
    rd(pst_pkg::CMD_TEMP, 1, 0, 48'h6789, 2);
    rd(pst_pkg::CMD_POUT, 0, 0, 48'h9abc, 2);
    // Phase current: total, each owned phase, foreign page, absent phase
    rd(pst_pkg::CMD_IOUT, 0, 8'hff, 48'hf018, 2);
    rd(pst_pkg::CMD_IOUT, 0, 0, 48'hf010, 2);
    rd(pst_pkg::CMD_IOUT, 0, 1, 48'hf008, 2);
    rd(pst_pkg::CMD_IOUT, 1, 0, 48'hf000, 2);
    acc(0, pst_pkg::CMD_IOUT, 0, 2, 48'h0, EM, EM);
    // Comms flags: read-only writes above set invalid data; then unknown code
    rd(pst_pkg::CMD_CML_FLG, 0, 0, 48'h40, 1);
    acc(0, 8'h00, 0, 0, 48'h0, EM, EM);
    rd(pst_pkg::CMD_CML_FLG, 0, 0, 48'hc0, 1);
    wr(pst_pkg::CMD_CML_FLG, 0, 48'hff, 0);
    // Pulse every condition on page 1; keep one vout cause live
    @(posedge clk);
    {vout_cond[1], iout_cond[1], temp_cond[1], mfr_cond[1], input_cond} <= '1;
    {busy, output_off, power_good} <= 6'b10_10_01;
    @(posedge clk);
    {iout_cond[1], temp_cond[1], mfr_cond[1], input_cond} <= '0;
    vout_cond <= {8'h80, 8'h80}; // Page 0 cause too, so the sticky check is reached
    rd(pst_pkg::CMD_SUM_BYTE, 1, 0, 48'hfd, 1);
    rd(pst_pkg::CMD_SUM_WORD, 1, 0, 48'hf8fd, 2);
    rd(pst_pkg::CMD_SUM_WORD, 0, 0, 48'ha028, 2);
    rd(pst_pkg::CMD_VOUT_FLG, 1, 0, 48'hbc, 1);
    rd(pst_pkg::CMD_IOUT_FLG, 1, 0, 48'hb8, 1);
    rd(pst_pkg::CMD_IN_FLG, 0, 0, 48'hdf, 1);
    rd(pst_pkg::CMD_TEMP_FLG, 1, 0, 48'hc0, 1);
    rd(pst_pkg::CMD_MFR_FLG, 1, 0, 48'hf8, 1);
    rd(pst_pkg::CMD_MFR_FLG, 0, 0, 48'h0, 1);
    acc(0, pst_pkg::CMD_VOUT_FLG, 2, 0, 48'h0, EM, EM);
    // Write-one clears, except where the cause is still present
    wr(pst_pkg::CMD_VOUT_FLG, 1, 48'hff, 0);
    rd(pst_pkg::CMD_VOUT_FLG, 1, 0, 48'h80, 1);
    wr(pst_pkg::CMD_IOUT_FLG, 1, 48'h08, 0);
    rd(pst_pkg::CMD_IOUT_FLG, 1, 0, 48'hb0, 1);
    wr(pst_pkg::CMD_SUM_BYTE, 1, 48'h04, 0);
    rd(pst_pkg::CMD_TEMP_FLG, 1, 0, 48'h0, 1);
    wr(pst_pkg::CMD_TEMP_FLG, 0, 48'hff, 0);
    rd(pst_pkg::CMD_TEMP_FLG, 0, 0, 48'h0, 1);
    wr(pst_pkg::CMD_PROTO_REV, 0, 48'h44, 1);
    rd(pst_pkg::CMD_PROTO_REV, 0, 0, 48'h33, 1);
    print_verdict();
  end
endmodule : testbench
